// ==== pmr_pkg.sv ====
// Behaviour
// RULE1: after logic supply start-up every spi register returns to its default
// RULE2: spi port and daisy chain work whenever logic supply is present, ignoring switch supply
// RULE3: first frame after any reset returns the output request register, error flag set
// RULE4: stand-by entered when mux select is default and channel 5 not on
// RULE5: entering stand-by clears all channel over-temperature latches; code keeps set a latch whose event is present at entry
// RULE6: stand-by flag is set the moment stand-by is entered
// RULE7: controller wakes the device by writing a non-default mux select
// RULE8: limp-home input wakes the device; each output then follows its own pin
// RULE9: crank latch of channel 5 is inoperative during limp-home
// RULE10: crank latch enable resets to one, latch mode active
// RULE11: in latch mode pin or request bit sets latch; channel stays on until cleared
// RULE12: controller releases latch by idling pin and request, then writing enable zero
// RULE13: present channel 5 on or off state readable in a status bit
// RULE14: no stand-by entry while channel 5 is on
// RULE15: every reset restores spi registers and error flags, power stages untouched
// RULE16: power-on reset released once logic supply reaches its minimum level
// RULE17: writing one to soft reset command acts like power-on reset
// RULE18: controller waits wake-up or transfer delay time after reset before access
// RULE19: in limp-home writable registers reset, writes ignored, reads still served
// RULE20: stand-by flag cleared as soon as a wake-up event leaves stand-by
package pmr_pkg;
    localparam int NUM_CH = 6;
    localparam int CRANK_CH = 5;
    localparam int FRAME_BITS = 16;
    // frame layout
    localparam int FRM_WR_BIT = 15;
    localparam int FRM_TER_BIT = 15;
    localparam int FRM_ADDR_MSB = 14;
    localparam int FRM_ADDR_LSB = 12;
    localparam int FRM_DATA_MSB = 7;
    // register addresses
    localparam logic [2:0] ADDR_OUT = 3'h0;
    localparam logic [2:0] ADDR_DCR = 3'h1;
    localparam logic [2:0] ADDR_HWCR = 3'h2;
    localparam logic [2:0] ADDR_STAT = 3'h3;
    // control and status register field positions
    localparam int HWCR_CTL_BIT = 0;
    localparam int SOFT_RESET_COMMAND_BIT = 1;
    localparam int STANDBY_FLAG_BIT = 1;
    localparam int CRANK_LATCH_ENABLE_BIT = 2;
    localparam int CH5_STATE_FLAG_BIT = 3;
    localparam int STAT_LHI_BIT = 0;
    // reset values
    localparam logic [5:0] OUT_RST = 6'h00;
    localparam logic [2:0] MUX_STANDBY = 3'h7;
    localparam logic LCH_RST = 1'b1;
    localparam logic CTL_RST = 1'b0;
    typedef logic [FRAME_BITS-1:0] pmr_word_t;
endpackage

// ==== pmr_link_if.sv ====
`timescale 1ns/1ns
interface pmr_link_if;
    import pmr_pkg::*;
    logic frame_done;
    logic frame_ok;
    pmr_word_t rx_word;
    pmr_word_t tx_word;
    modport shifter (
        output frame_done,
        output frame_ok,
        output rx_word,
        input tx_word
    );
    modport core (
        input frame_done,
        input frame_ok,
        input rx_word,
        output tx_word
    );
endinterface

// ==== pmr_spi_shift.sv ====
`timescale 1ns/1ns
module pmr_spi_shift #(
    parameter int FRAME_W = pmr_pkg::FRAME_BITS
) (
    input wire logic core_clk_in,  // system clock
    input wire logic srst_in,  // sync reset
    input wire logic cs_n_in,  // chip select pin
    input wire logic sclk_in,  // serial clock pin
    input wire logic si_in,  // serial data in pin
    output logic so_out,  // serial data out
    output logic so_oe_out,  // so drive enable
    pmr_link_if.shifter link  // word side
);
    import pmr_pkg::*;

    localparam int CW = $clog2(FRAME_W + 1);

    if (FRAME_W != FRAME_BITS) begin : g_chk
        $error("frame width must match the frame layout");
    end

    logic [2:0] cs_sync_q;
    logic [2:0] sclk_sync_q;
    logic [1:0] si_sync_q;
    logic [FRAME_W-1:0] shreg_q;
    logic [CW-1:0] cnt_q;
    logic so_q;
    logic done_q;
    logic ok_q;
    pmr_word_t rx_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic active;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cs_sync_q <= 3'h7;
            sclk_sync_q <= 3'h0;
            si_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], cs_n_in};
            sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
            si_sync_q <= {si_sync_q[0], si_in};
        end
    end

    assign active = ~cs_sync_q[1];
    assign cs_fall = cs_sync_q[2] & ~cs_sync_q[1];
    assign cs_rise = ~cs_sync_q[2] & cs_sync_q[1];
    assign sclk_rise = active & ~sclk_sync_q[2] & sclk_sync_q[1];
    assign sclk_fall = active & sclk_sync_q[2] & ~sclk_sync_q[1];

    // shift register doubles as daisy chain path
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            shreg_q <= '0;
            cnt_q <= '0;
        end else if (cs_fall) begin
            shreg_q <= link.tx_word;
            cnt_q <= '0;
        end else if (sclk_rise) begin
            shreg_q <= {shreg_q[FRAME_W-2:0], si_sync_q[1]};
            if (cnt_q != CW'(FRAME_W + 1)) begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            so_q <= 1'b0;
        end else if (cs_fall) begin
            so_q <= link.tx_word[FRAME_W-1];
        end else if (sclk_fall) begin
            so_q <= shreg_q[FRAME_W-1];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            done_q <= 1'b0;
            ok_q <= 1'b0;
            rx_q <= '0;
        end else begin
            done_q <= cs_rise;
            if (cs_rise) begin
                ok_q <= (cnt_q == CW'(FRAME_W));
                rx_q <= shreg_q;
            end
        end
    end

    assign so_out = so_q;
    assign so_oe_out = active;
    assign link.frame_done = done_q;
    assign link.frame_ok = ok_q;
    assign link.rx_word = rx_q;
endmodule

// ==== pmr_power_ctrl.sv ====
`timescale 1ns/1ns
module pmr_power_ctrl #(
    parameter int CH = pmr_pkg::NUM_CH
) (
    input wire logic core_clk_in,  // system clock, 50 MHz
    input wire logic srst_in,  // logic supply power-on reset
    input wire logic pstage_rst_in,  // switch supply reset of power stages
    input wire logic spi_cs_n_in,  // spi chip select, low active
    input wire logic spi_sclk_in,  // spi clock
    input wire logic spi_si_in,  // spi serial in
    output logic spi_so_out,  // spi serial out
    output logic spi_so_oe_out,  // spi out drive enable
    input wire logic limp_home_input_in,  // limp-home pin
    input wire logic [CH-1:0] channel_input_pins_in,  // direct input pins
    input wire logic [CH-1:0] overtemp_in,  // over-temperature events
    output logic [CH-1:0] channel_outputs_out,  // power stage gate commands
    output logic standby_flag_out,  // device in stand-by
    output logic ch5_state_flag_out,  // channel 5 on
    output logic crank_latch_enable_out,  // latch mode enabled
    output logic [2:0] sense_mux_select_out,  // sense mux select
    output logic limp_home_active_out,  // limp-home active
    output logic transfer_error_flag_out  // transfer error flag
);
    import pmr_pkg::*;

    if (CH != NUM_CH || CRANK_CH >= CH) begin : g_chk
        $error("channel count must match the register layout");
    end

    if (CH > FRM_DATA_MSB + 1) begin : g_req_chk
        $error("output requests must fit the data byte");
    end

    if (CH5_STATE_FLAG_BIT > FRM_DATA_MSB || STAT_LHI_BIT > FRM_DATA_MSB) begin : g_fld_chk
        $error("status bits must fit the data byte");
    end

    pmr_link_if link ();

    // spi runs on logic supply alone
    pmr_spi_shift #(
        .FRAME_W(FRAME_BITS)
    ) u_spi (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),  // RULE2
        .cs_n_in(spi_cs_n_in),
        .sclk_in(spi_sclk_in),
        .si_in(spi_si_in),
        .so_out(spi_so_out),
        .so_oe_out(spi_so_oe_out),
        .link(link.shifter)
    );

    function automatic logic [2:0] frame_addr(input pmr_word_t w);
        frame_addr = w[FRM_ADDR_MSB:FRM_ADDR_LSB];
    endfunction

    // write strobe for one register address
    function automatic logic wr_hit(input logic ok, input logic [2:0] a, input logic [2:0] sel);
        wr_hit = ok & (a == sel);
    endfunction

    // reply word: error flag, echoed address, data byte
    function automatic pmr_word_t reply_word(input logic err, input logic [2:0] a,
            input logic [FRM_DATA_MSB:0] d);
        reply_word = '0;
        reply_word[FRM_TER_BIT] = err;
        reply_word[FRM_ADDR_MSB:FRM_ADDR_LSB] = a;
        reply_word[FRM_DATA_MSB:0] = d;
    endfunction

    // pin synchronisers
    logic [1:0] limp_sync_q;
    logic [CH-1:0] pin_s1_q;
    logic [CH-1:0] pin_s2_q;
    logic [CH-1:0] ot_s1_q;
    logic [CH-1:0] ot_s2_q;

    // stage-side syncs follow the switch supply only, not spi resets
    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            limp_sync_q <= 2'h0;
        end else begin
            limp_sync_q <= {limp_sync_q[0], limp_home_input_in};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= channel_input_pins_in;
            pin_s2_q <= pin_s1_q;  // RULE15
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            ot_s1_q <= '0;
            ot_s2_q <= '0;
        end else begin
            ot_s1_q <= overtemp_in;
            ot_s2_q <= ot_s1_q;
        end
    end

    logic limp;
    assign limp = limp_sync_q[1];

    // register bank
    logic [CH-1:0] out_req_q;
    logic [2:0] mux_q;
    logic lch_q;
    logic ctl_q;
    logic soft_rst_q;
    logic ter_q;
    logic [2:0] rd_addr_q;
    pmr_word_t tx_q;
    logic rst_any;
    logic wr_ok;
    logic [2:0] wr_addr;
    logic [FRM_DATA_MSB:0] wr_data;

    assign rst_any = srst_in | soft_rst_q;  // RULE1 RULE16 RULE17
    assign wr_addr = frame_addr(link.rx_word);
    assign wr_data = link.rx_word[FRM_DATA_MSB:0];
    // writes dropped in limp-home
    assign wr_ok = link.frame_done & link.frame_ok & link.rx_word[FRM_WR_BIT]
        & ~limp;  // RULE19

    // writable registers held at defaults through limp-home
    always_ff @(posedge core_clk_in) begin
        if (rst_any | limp) begin
            out_req_q <= OUT_RST;  // RULE15 RULE19
        end else if (wr_hit(wr_ok, wr_addr, ADDR_OUT)) begin
            out_req_q <= wr_data[CH-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_any | limp) begin
            mux_q <= MUX_STANDBY;
        end else if (wr_hit(wr_ok, wr_addr, ADDR_DCR)) begin
            mux_q <= wr_data[2:0];  // RULE7
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_any | limp) begin
            lch_q <= LCH_RST;  // RULE10
            ctl_q <= CTL_RST;
        end else if (wr_hit(wr_ok, wr_addr, ADDR_HWCR)) begin
            lch_q <= wr_data[CRANK_LATCH_ENABLE_BIT];
            ctl_q <= wr_data[HWCR_CTL_BIT];
        end
    end

    // one-cycle soft reset pulse
    always_ff @(posedge core_clk_in) begin
        if (rst_any) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_hit(wr_ok, wr_addr, ADDR_HWCR) & wr_data[SOFT_RESET_COMMAND_BIT];  // RULE17
        end
    end

    // error flag: reset or bad frame sets, good frame clears; set wins
    always_ff @(posedge core_clk_in) begin
        if (rst_any) begin
            ter_q <= 1'b1;  // RULE3 RULE15
        end else if (link.frame_done & ~link.frame_ok) begin
            ter_q <= 1'b1;
        end else if (link.frame_done) begin
            ter_q <= 1'b0;
        end
    end

    // address whose contents the next frame returns
    always_ff @(posedge core_clk_in) begin
        if (rst_any) begin
            rd_addr_q <= ADDR_OUT;  // RULE3
        end else if (link.frame_done & link.frame_ok) begin
            rd_addr_q <= wr_addr;
        end
    end

    // power stage side, untouched by spi resets
    logic [CH-1:0] ot_latch_q;
    logic crank_q;
    logic standby_q;
    logic [CH-1:0] ch_on_q;
    logic [CH-1:0] ch_req;
    logic [CH-1:0] ch_on_d;
    logic ch5_on;
    logic stb_cond;
    logic stb_entry;
    logic [CH-1:0] ot_block;

    // limp-home: pins only
    assign ch_req = limp ? pin_s2_q : (pin_s2_q | out_req_q);  // RULE8

    // crank latch: set in latch mode, cleared in limp-home or when idle and unlatched
    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            crank_q <= 1'b0;
        end else if (limp) begin
            crank_q <= 1'b0;  // RULE9
        end else if (lch_q & ch_req[CRANK_CH]) begin
            crank_q <= 1'b1;  // RULE11
        end else if (~lch_q & ~ch_req[CRANK_CH]) begin
            crank_q <= 1'b0;  // RULE12
        end
    end

    // a fresh event blocks a stage before its latch is set
    assign ot_block = ot_latch_q | ot_s2_q;

    always_comb begin
        ch_on_d = ch_req & ~ot_block;
        // latched channel stays on until cleared
        ch_on_d[CRANK_CH] = crank_q
            | (ch_req[CRANK_CH] & ~ot_block[CRANK_CH]);  // RULE11
    end

    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            ch_on_q <= '0;
        end else begin
            ch_on_q <= ch_on_d;  // RULE15
        end
    end

    assign ch5_on = ch_on_q[CRANK_CH];
    assign stb_cond = (mux_q == MUX_STANDBY) & ~ch5_on & ~limp;  // RULE4 RULE14
    assign stb_entry = stb_cond & ~standby_q;

    // stand-by follows the mux default while channel 5 and limp-home are off

    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            standby_q <= 1'b0;
        end else if (stb_cond) begin
            standby_q <= 1'b1;  // RULE6
        end else begin
            standby_q <= 1'b0;  // RULE20
        end
    end

    // new event wins over the stand-by clear
    always_ff @(posedge core_clk_in) begin
        if (pstage_rst_in) begin
            ot_latch_q <= '0;
        end else if (stb_entry) begin
            ot_latch_q <= ot_s2_q;  // RULE5
        end else begin
            ot_latch_q <= ot_latch_q | ot_s2_q;
        end
    end

    // read data for the next frame
    logic [FRM_DATA_MSB:0] rd_data;

    always_comb begin
        rd_data = '0;
        case (rd_addr_q)
            ADDR_OUT: begin
                rd_data[CH-1:0] = out_req_q;
            end
            ADDR_DCR: begin
                rd_data[2:0] = mux_q;
            end
            ADDR_HWCR: begin
                rd_data[HWCR_CTL_BIT] = ctl_q;
                rd_data[STANDBY_FLAG_BIT] = standby_q;
                rd_data[CRANK_LATCH_ENABLE_BIT] = lch_q;
                rd_data[CH5_STATE_FLAG_BIT] = ch5_on;  // RULE13
            end
            ADDR_STAT: begin
                rd_data[STAT_LHI_BIT] = limp;  // RULE19
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tx_q <= '0;
        end else begin
            // refreshed every cycle so a frame start sees current status
            tx_q <= reply_word(ter_q, rd_addr_q, rd_data);  // RULE3
        end
    end

    assign link.tx_word = tx_q;

    assign channel_outputs_out = ch_on_q;
    assign standby_flag_out = standby_q;
    assign ch5_state_flag_out = ch5_on;
    assign crank_latch_enable_out = lch_q;
    assign sense_mux_select_out = mux_q;
    assign limp_home_active_out = limp;
    assign transfer_error_flag_out = ter_q;
endmodule

// ==== pmr_power_ctrl_sva.sv ====
`timescale 1ns/1ns
module pmr_power_ctrl_sva
    import pmr_pkg::*;
#(
    parameter int CH = 6
) (
    input wire logic core_clk_in,  // system clock
    input wire logic srst_in,  // sync reset
    input wire logic pstage_rst_in,  // power stage reset
    input wire logic spi_cs_n_in,  // chip select
    input wire logic spi_so_oe_out,  // so drive enable
    input wire logic [CH-1:0] channel_input_pins_in,  // channel pins
    input wire logic [CH-1:0] channel_outputs_out,  // channel states
    input wire logic standby_flag_out,  // stand-by flag
    input wire logic ch5_state_flag_out,  // channel 5 on
    input wire logic crank_latch_enable_out,  // latch mode
    input wire logic [2:0] sense_mux_select_out,  // mux select
    input wire logic limp_home_active_out,  // limp-home active
    input wire logic transfer_error_flag_out  // error flag
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    chk_ch5_flag_mirror: assert property (ch5_state_flag_out == channel_outputs_out[CRANK_CH])
        else $error("channel 5 flag differs from channel 5 output");
    chk_reset_defaults: assert property ($fell(srst_in) |->
        sense_mux_select_out == 3'h7 && crank_latch_enable_out && transfer_error_flag_out)
        else $error("defaults missing after reset");
    chk_no_stb_ch5_on: assert property (ch5_state_flag_out [*3] |-> !standby_flag_out)
        else $error("stand-by while channel 5 on");
    chk_stb_entry_mux: assert property ($rose(standby_flag_out) |->
        $past(sense_mux_select_out) == 3'h7)
        else $error("stand-by entered with mux not at default");
    chk_wake_clears_stb: assert property (sense_mux_select_out != 3'h7 |->
        ##[0:2] !standby_flag_out)
        else $error("stand-by flag kept after wake-up");
    chk_limp_follow: assert property ((limp_home_active_out &&
        $stable(channel_input_pins_in)) [*5] |-> channel_outputs_out == channel_input_pins_in)
        else $error("limp-home outputs do not follow pins");
    chk_limp_defaults: assert property (limp_home_active_out [*3] |->
        sense_mux_select_out == 3'h7 && crank_latch_enable_out)
        else $error("writable registers not at default in limp-home");
    chk_crank_hold: assert property (crank_latch_enable_out && ch5_state_flag_out &&
        !limp_home_active_out && !pstage_rst_in |=> ch5_state_flag_out)
        else $error("latched channel 5 dropped");
    chk_oe_on_frame: assert property ($fell(spi_cs_n_in) |-> ##[1:4] spi_so_oe_out)
        else $error("serial out not driven in frame");

    cov_stb_entry: cover property ($rose(standby_flag_out));
    cov_limp_on: cover property (limp_home_active_out && channel_outputs_out != '0);
    cov_ch5_release: cover property ($fell(ch5_state_flag_out));
endmodule

// ==== pmr_spi_master.sv ====
`timescale 1ns/1ns
module pmr_spi_master (
    output logic cs_n_out,  // chip select
    output logic sclk_out,  // serial clock
    output logic si_out,  // data to device
    input wire logic so_in  // data from device
);
    import pmr_pkg::*;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
    end
    // nbits other than 16 only for refused frames
    task automatic xfer(input pmr_word_t tx, input int nbits, output pmr_word_t rx);
        rx = '0;
        cs_n_out = 1'b0;
        #160;
        for (int i = 0; i < nbits; i++) begin
            si_out = tx[FRAME_BITS-1-i];
            #80;
            sclk_out = 1'b1;
            rx = {rx[FRAME_BITS-2:0], so_in};
            #80;
            sclk_out = 1'b0;
        end
        #80;
        cs_n_out = 1'b1;
        si_out = ~si_out;
        #240;
    endtask
endmodule

// ==== power_mode_reset_crank_latch_tb.sv ====
`timescale 1ns/1ns
module power_mode_reset_crank_latch_tb;
    import pmr_pkg::*;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic pstage_rst_in = 1'b1;
    logic limp_in = 1'b0;
    logic [NUM_CH-1:0] pins = '0;
    logic [NUM_CH-1:0] otemp = '0;
    logic cs_n, sclk, si, so, so_oe, stb, ch5, lch, limp, transfer_error_flag;
    logic [NUM_CH-1:0] outs;
    logic [2:0] mux;
    pmr_word_t rx;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    always #10 core_clk_in = ~core_clk_in;

    pmr_power_ctrl i_pmr_power_ctrl (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .pstage_rst_in(pstage_rst_in),
        .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_si_in(si), .spi_so_out(so),
        .spi_so_oe_out(so_oe), .limp_home_input_in(limp_in), .channel_input_pins_in(pins),
        .overtemp_in(otemp), .channel_outputs_out(outs), .standby_flag_out(stb),
        .ch5_state_flag_out(ch5), .crank_latch_enable_out(lch),
        .sense_mux_select_out(mux), .limp_home_active_out(limp), .transfer_error_flag_out(transfer_error_flag)
    );
    pmr_spi_master i_pmr_spi_master (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    task automatic frm(input pmr_word_t w);
        i_pmr_spi_master.xfer(w, FRAME_BITS, rx);
    endtask

    task automatic t_reset();
        check(mux, 16'h7);
        check(lch, 16'h1);
        check(transfer_error_flag, 16'h1);
        check(stb, 16'h1);
        frm(16'h2000);
        check(rx, 16'h8000);
        frm(16'h2000);
        check(rx, 16'h2006);
    endtask

    task automatic t_thermal();
        frm(16'h9003);
        check(mux, 16'h3);
        check(stb, 16'h0);
        otemp = 6'h01;
        pins = 6'h01;
        wait_clk(8);
        otemp = 6'h00;
        wait_clk(8);
        check(outs, 16'h0);
        frm(16'h9007);
        check(stb, 16'h1);
        check(outs, 16'h1);
        pins = 6'h00;
    endtask

    task automatic t_crank();
        frm(16'h9003);
        frm(16'h8020);
        frm(16'h8000);
        frm(16'h9007);
        check(ch5, 16'h1);
        check(stb, 16'h0);
        frm(16'h2000);
        frm(16'h2000);
        check(rx, 16'h200C);
        srst_in = 1'b1;
        wait_clk(4);
        srst_in = 1'b0;
        wait_clk(4);
        check(ch5, 16'h1);
        check(transfer_error_flag, 16'h1);
        frm(16'hA001);
        check(lch, 16'h0);
        check(ch5, 16'h0);
        wait_clk(2);
        check(stb, 16'h1);
    endtask

    task automatic t_soft();
        frm(16'h9005);
        check(rx, 16'h2003);
        check(mux, 16'h5);
        frm(16'hA006);
        check(rx, 16'h1005);
        check(mux, 16'h7);
        check(lch, 16'h1);
        check(transfer_error_flag, 16'h1);
        frm(16'h2000);
        check(rx, 16'h8000);
        check(transfer_error_flag, 16'h0);
        i_pmr_spi_master.xfer(16'h9001, 12, rx);
        check(transfer_error_flag, 16'h1);
        check(mux, 16'h7);
    endtask

    task automatic t_limp();
        frm(16'h9002);
        limp_in = 1'b1;
        pins = 6'h2A;
        wait_clk(8);
        check(limp, 16'h1);
        check(mux, 16'h7);
        check(outs, 16'h2A);
        frm(16'h9003);
        check(mux, 16'h7);
        frm(16'h3000);
        frm(16'h3000);
        check(rx, 16'h3001);
        pins = 6'h00;
        wait_clk(8);
        check(ch5, 16'h0);
        limp_in = 1'b0;
        wait_clk(8);
        check(stb, 16'h1);
    endtask

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        wait_clk(8);
        srst_in = 1'b0;
        pstage_rst_in = 1'b0;
        wait_clk(4);
        t_reset();
        t_thermal();
        t_crank();
        t_soft();
        t_limp();
        final_report();
    end
endmodule

bind pmr_power_ctrl pmr_power_ctrl_sva #(.CH(CH)) i_pmr_power_ctrl_sva (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .pstage_rst_in(pstage_rst_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_so_oe_out(spi_so_oe_out),
    .channel_input_pins_in(channel_input_pins_in), .channel_outputs_out(channel_outputs_out),
    .standby_flag_out(standby_flag_out), .ch5_state_flag_out(ch5_state_flag_out),
    .crank_latch_enable_out(crank_latch_enable_out),
    .sense_mux_select_out(sense_mux_select_out), .limp_home_active_out(limp_home_active_out),
    .transfer_error_flag_out(transfer_error_flag_out)
);
